// ===== pie_agent.sv
// interrupting agents on the far side of the entry block
`timescale 1ns/1ps
`default_nettype none
`include "pie_params.svh"
module pie_agent (
  input  wire logic [`PIE_NUM_DIRECT-1:0] clk_req_i,    // clocked agents' requests
  input  wire logic                       clk_i,        // processor clock
  input  wire logic                       resetn_i,     // async reset, low
  input  wire logic [`PIE_NUM_SYNC-1:0]   free_req_i,   // free-running agents' requests
  output logic      [`PIE_NUM_DIRECT-1:0] irq_direct_o, // clocked interrupt lines
  output wire logic [`PIE_NUM_SYNC-1:0]   irq_async_o   // unclocked interrupt lines
);
  // clocked agents run off the processor clock, so their lines move only at its edge
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_direct_o <= '0;
    end else begin
      irq_direct_o <= clk_req_i;
    end
  end
  // free-running agents: edge skewed well away from the processor edge
  assign #13 irq_async_o = free_req_i;
endmodule
`default_nettype wire

// ===== pie_core.sv
// interrupt recognition and precise exception entry
// Functional notes
// - on taking an interrupt, abort all instructions after the interrupted point
// - halt the running process as soon as the interrupt is accepted
// - exception entry loads the return address register with the resume address
// - exception entry loads cause code and pending interrupt bits
// - exception entry clears the current kernel/user bit
// - exception entry clears the current interrupt enable bit
// - the fetch after detection comes from the general exception vector
// - all exceptions use the general vector except reset and user miss
// - recognition only while the pipeline runs; stalls delay it
// - synchronised inputs pass a two-flop synchroniser, three cycles to vector
// - direct inputs reach the vector fetch with one cycle latency
// - no general register is saved by hardware on entry
// - branch instructions can test each branch condition input level
// - four branch condition inputs are provided
// - the mask field gates each interrupt source individually
`timescale 1ns/1ps
`default_nettype none
`include "pie_params.svh"
module pie_core (
  input  wire logic                        clk_i,          // processor clock
  input  wire logic                        resetn_i,       // async reset, low
  input  wire logic [`PIE_NUM_DIRECT-1:0]  irq_direct_i,   // pre-synchronised irqs
  input  wire logic [`PIE_NUM_SYNC-1:0]    irq_async_i,    // asynchronous irqs
  input  wire logic                        pipe_run_i,     // pipeline not stalled
  input  wire logic [31:0]                 resume_pc_i,    // resume address of oldest live instr
  input  wire logic                        other_exc_i,    // non-interrupt exception request
  input  wire logic [4:0]                  other_code_i,   // its exception code
  input  wire logic                        sr_wr_i,        // software writes status
  input  wire logic [15:0]                 sr_wdata_i,     // status write data
  input  wire logic                        rfe_i,          // return from exception
  input  wire logic [`PIE_NUM_BRCOND-1:0]  branch_condition_input_i, // branch test pins
  input  wire logic [1:0]                  bc_sel_i,       // branch condition selected
  output logic                             bc_true_o,      // selected condition level
  output logic                             abort_o,        // kill younger instructions
  output logic                             halt_o,         // hold current process
  output logic                             vec_load_o,     // redirect fetch pulse
  output logic      [31:0]                 vec_addr_o,     // fetch redirect address
  output logic      [31:0]                 epc_o,          // exception return address
  output logic      [4:0]                  exception_code_field_o, // cause code
  output logic      [`PIE_NUM_IRQ-1:0]     pending_irq_field_o,    // raw pending bits
  output logic      [15:0]                 status_o        // status register
);
  logic [`PIE_NUM_SYNC-1:0] irq_sync;
  pie_sync u_sync (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .async_i  (irq_async_i),
    .sync_o   (irq_sync)
  );

  function automatic logic [31:0] pie_vector(input logic [4:0] code);
    if (code == `PIE_EXC_UTLB_LD || code == `PIE_EXC_UTLB_ST)
      pie_vector = `PIE_UTLB_VECTOR;
    else
      pie_vector = `PIE_GEN_VECTOR;
  endfunction

  logic [`PIE_NUM_IRQ-1:0] raw_irq;
  logic [`PIE_NUM_IRQ-1:0] live_irq;
  logic                    take_irq;
  logic                    take_exc;
  pie_pkg::pie_state_type  state_r, state_nxt;
  logic [15:0]             sr_r, sr_nxt;
  logic [31:0]             epc_r, epc_nxt;
  logic [4:0]              code_r, code_nxt;
  logic [`PIE_NUM_IRQ-1:0] pend_r, pend_nxt;
  logic                    abort_r, abort_nxt;
  logic                    halt_r, halt_nxt;
  logic                    vld_r, vld_nxt;
  logic [31:0]             vaddr_r, vaddr_nxt;
  logic                    bc_r, bc_nxt;

  // direct bits are used as they arrive, two stages shorter than the synced ones
  assign raw_irq  = {irq_direct_i, irq_sync};
  assign live_irq = raw_irq & sr_r[`PIE_MASK_LSB +: `PIE_NUM_IRQ];
  // stalls hold recognition off; nothing is lost since irq lines are levels
  assign take_irq = pipe_run_i && sr_r[`PIE_IEC_BIT] && (|live_irq)
                    && (state_r == pie_pkg::PIE_RUN);
  assign take_exc = pipe_run_i && other_exc_i && (state_r == pie_pkg::PIE_RUN);

  always_comb begin
    state_nxt = state_r;
    sr_nxt    = sr_r;
    epc_nxt   = epc_r;
    code_nxt  = code_r;
    abort_nxt = 1'b0;
    halt_nxt  = 1'b0;
    vld_nxt   = 1'b0;
    vaddr_nxt = vaddr_r;
    pend_nxt  = raw_irq; // unmasked view
    bc_nxt    = branch_condition_input_i[bc_sel_i];
    case (state_r)
      pie_pkg::PIE_RUN: begin
        if (sr_wr_i) begin
          sr_nxt = sr_wdata_i;
        end else if (rfe_i) begin
          sr_nxt[`PIE_STACK_MSB:0] = sr_r[`PIE_STACK_MSB:0] >> `PIE_STACK_STEP;
        end
        if (take_irq || take_exc) begin
          halt_nxt  = 1'b1;
          abort_nxt = 1'b1;
          epc_nxt   = resume_pc_i;
          code_nxt  = take_exc ? other_code_i : `PIE_EXC_INT;
          // push the kernel/enable stack, current pair goes to zero
          sr_nxt[`PIE_STACK_MSB:0] = sr_r[`PIE_STACK_MSB:0] << `PIE_STACK_STEP;
          vld_nxt   = 1'b1;
          vaddr_nxt = take_exc ? pie_vector(other_code_i) : `PIE_GEN_VECTOR;
          state_nxt = pie_pkg::PIE_ENTER;
        end
      end
      pie_pkg::PIE_ENTER: begin
        // only state is saved; register context is left to the handler
        // status writes are dropped here so the pushed stack cannot be overwritten
        state_nxt = pie_pkg::PIE_KERN;
      end
      pie_pkg::PIE_KERN: begin
        state_nxt = pie_pkg::PIE_RUN;
        if (sr_wr_i) begin
          sr_nxt = sr_wdata_i;
        end
      end
      default: begin
        state_nxt = pie_pkg::PIE_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= pie_pkg::PIE_RUN;
      sr_r    <= `PIE_SR_RESET;
      epc_r   <= '0;
      code_r  <= '0;
      pend_r  <= '0;
      abort_r <= 1'b0;
      halt_r  <= 1'b0;
      vld_r   <= 1'b0;
      vaddr_r <= `PIE_RESET_VECTOR;
      bc_r    <= 1'b0;
    end else begin
      state_r <= state_nxt;
      sr_r    <= sr_nxt;
      epc_r   <= epc_nxt;
      code_r  <= code_nxt;
      pend_r  <= pend_nxt;
      abort_r <= abort_nxt;
      halt_r  <= halt_nxt;
      vld_r   <= vld_nxt;
      vaddr_r <= vaddr_nxt;
      bc_r    <= bc_nxt;
    end
  end

  assign bc_true_o              = bc_r;
  assign abort_o                = abort_r;
  assign halt_o                 = halt_r;
  assign vec_load_o             = vld_r;
  assign vec_addr_o             = vaddr_r;
  assign epc_o                  = epc_r;
  assign exception_code_field_o = code_r;
  assign pending_irq_field_o    = pend_r;
  assign status_o               = sr_r;

  chk_entry_vector: assert property (@(posedge clk_i) disable iff (!resetn_i)
    take_irq && !take_exc |=> vec_load_o && vec_addr_o == `PIE_GEN_VECTOR)
    else $error("interrupt did not redirect to general vector");
  chk_abort_halt: assert property (@(posedge clk_i) disable iff (!resetn_i)
    vec_load_o |-> abort_o && halt_o)
    else $error("redirect without abort and halt");
  chk_halt_cause: assert property (@(posedge clk_i) disable iff (!resetn_i)
    halt_o |-> $past(take_irq) || $past(take_exc))
    else $error("halt without accepted exception");
  chk_epc_load: assert property (@(posedge clk_i) disable iff (!resetn_i)
    take_irq || take_exc |=> epc_o == $past(resume_pc_i))
    else $error("return address not captured");
  chk_int_code: assert property (@(posedge clk_i) disable iff (!resetn_i)
    take_irq && !take_exc |=> exception_code_field_o == `PIE_EXC_INT)
    else $error("wrong cause code for interrupt");
  chk_kernel_mode: assert property (@(posedge clk_i) disable iff (!resetn_i)
    vec_load_o |-> !status_o[`PIE_KUC_BIT] && status_o[`PIE_KUP_BIT] == $past(status_o[`PIE_KUC_BIT]))
    else $error("kernel mode not entered");
  chk_ie_clear: assert property (@(posedge clk_i) disable iff (!resetn_i)
    vec_load_o |-> !status_o[`PIE_IEC_BIT] ##1 !take_irq)
    else $error("interrupt enable not cleared");
  chk_utlb_vector: assert property (@(posedge clk_i) disable iff (!resetn_i)
    take_exc && (other_code_i == `PIE_EXC_UTLB_LD || other_code_i == `PIE_EXC_UTLB_ST)
    |=> vec_addr_o == `PIE_UTLB_VECTOR)
    else $error("user miss used wrong vector");
  chk_stall_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !pipe_run_i |=> !vec_load_o)
    else $error("exception taken during stall");
  chk_sync_lat: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(irq_async_i[0]) ##1 1'b1 |-> !irq_sync[0] || $past(irq_sync[0]))
    else $error("synchronised irq arrived too early");
  chk_direct_lat: assert property (@(posedge clk_i) disable iff (!resetn_i)
    pipe_run_i && irq_direct_i[0] && sr_r[`PIE_MASK_LSB+`PIE_NUM_SYNC] && sr_r[`PIE_IEC_BIT]
    && state_r == pie_pkg::PIE_RUN && !other_exc_i |=> vec_load_o)
    else $error("direct irq missed one cycle latency");
  chk_mask_gate: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (raw_irq & sr_r[`PIE_MASK_LSB +: `PIE_NUM_IRQ]) == '0 && !other_exc_i |=> !vec_load_o)
    else $error("masked irq was taken");
  chk_pending_raw: assert property (@(posedge clk_i) disable iff (!resetn_i)
    1'b1 |=> pending_irq_field_o == $past(raw_irq))
    else $error("pending field not raw");
  chk_bc_level: assert property (@(posedge clk_i) disable iff (!resetn_i)
    1'b1 |=> bc_true_o == $past(branch_condition_input_i[bc_sel_i]))
    else $error("branch condition level wrong");
  cov_irq_entry: cover property (@(posedge clk_i) disable iff (!resetn_i) take_irq);
  cov_utlb: cover property (@(posedge clk_i) disable iff (!resetn_i)
    vec_load_o && vec_addr_o == `PIE_UTLB_VECTOR);
  cov_stall_irq: cover property (@(posedge clk_i) disable iff (!resetn_i)
    !pipe_run_i && (|live_irq) ##1 take_irq);
  chk_entry_spacing: assert property (@(posedge clk_i) disable iff (!resetn_i)
    vec_load_o |=> !vec_load_o ##1 !vec_load_o)
    else $error("exception taken during entry");
  cov_write_refused: cover property (@(posedge clk_i) disable iff (!resetn_i)
    state_r == pie_pkg::PIE_ENTER && sr_wr_i);
  cov_rfe_pop: cover property (@(posedge clk_i) disable iff (!resetn_i)
    state_r == pie_pkg::PIE_RUN && rfe_i && !sr_wr_i);
endmodule
`default_nettype wire

// ===== pie_params.svh
// constants for the precise interrupt entry block
`ifndef PIE_PARAMS_SVH
`define PIE_PARAMS_SVH
`define PIE_NUM_DIRECT    3
`define PIE_NUM_SYNC      3
`define PIE_NUM_IRQ       6
`define PIE_NUM_BRCOND    4
`define PIE_GEN_VECTOR    32'h8000_0080
`define PIE_UTLB_VECTOR   32'h8000_0000
`define PIE_RESET_VECTOR  32'hBFC0_0000
`define PIE_EXC_INT       5'h00
`define PIE_EXC_UTLB_LD   5'h02
`define PIE_EXC_UTLB_ST   5'h03
`define PIE_KUC_BIT       1
`define PIE_KUP_BIT       3
`define PIE_STACK_MSB     5
`define PIE_STACK_STEP    2
`define PIE_IEC_BIT       0
`define PIE_MASK_LSB      8
`define PIE_SR_RESET      16'h0000
`define PIE_SYNC_STAGES   2
`endif

// ===== pie_pkg.sv
// types for the precise interrupt entry block
`default_nettype none
package pie_pkg;
  typedef enum logic [1:0] {
    PIE_RUN   = 2'b00,
    PIE_ENTER = 2'b01,
    PIE_KERN  = 2'b10
  } pie_state_type;
endpackage
`default_nettype wire

// ===== pie_sync.sv
// two-flop synchroniser for asynchronous interrupt inputs
`timescale 1ns/1ps
`default_nettype none
`include "pie_params.svh"
module pie_sync (
  input  wire logic                       clk_i,    // processor clock
  input  wire logic                       resetn_i, // async reset, low
  input  wire logic [`PIE_NUM_SYNC-1:0]   async_i,  // raw interrupt levels
  output logic      [`PIE_NUM_SYNC-1:0]   sync_o    // synchronised levels
);
  logic [`PIE_NUM_SYNC-1:0] meta_r;
  logic [`PIE_NUM_SYNC-1:0] meta_nxt;
  logic [`PIE_NUM_SYNC-1:0] sync_r;
  logic [`PIE_NUM_SYNC-1:0] sync_nxt;

  always_comb begin
    meta_nxt = async_i;
    sync_nxt = meta_r; // first flop read only here
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_o = sync_r;
endmodule
`default_nettype wire

// ===== precise_interrupt_entry_test.sv
// self-checking bench for the precise interrupt entry block
`timescale 1ns/1ps
`default_nettype none
`include "pie_params.svh"
module precise_interrupt_entry_test;
  logic        clk_i, resetn_i, pipe_run_i, other_exc_i, sr_wr_i, bc_true_o;
  logic        abort_o, halt_o, vec_load_o, rfe_i;
  logic [4:0]  u_codes [4] = '{`PIE_EXC_UTLB_LD, `PIE_EXC_UTLB_ST, 5'h04, 5'h08};
  logic [2:0]  dreq, areq, irq_d, irq_a;
  logic [31:0] resume_pc_i, vec_addr_o, epc_o;
  logic [4:0]  other_code_i, code_o;
  logic [15:0] sr_wdata_i, status_o;
  logic [3:0]  bc_pins;
  logic [1:0]  bc_sel_i;
  logic [5:0]  pend_o;
  int          n_errors, n_compared;
  pie_agent u_pie_agent (.clk_i(clk_i), .resetn_i(resetn_i), .clk_req_i(dreq),
    .free_req_i(areq), .irq_direct_o(irq_d), .irq_async_o(irq_a));
  pie_core u_pie_core (.clk_i(clk_i), .resetn_i(resetn_i), .irq_direct_i(irq_d),
    .irq_async_i(irq_a), .pipe_run_i(pipe_run_i), .resume_pc_i(resume_pc_i),
    .other_exc_i(other_exc_i), .other_code_i(other_code_i), .sr_wr_i(sr_wr_i),
    .sr_wdata_i(sr_wdata_i), .rfe_i(rfe_i), .branch_condition_input_i(bc_pins),
    .bc_sel_i(bc_sel_i), .bc_true_o(bc_true_o), .abort_o(abort_o), .halt_o(halt_o),
    .vec_load_o(vec_load_o), .vec_addr_o(vec_addr_o), .epc_o(epc_o),
    .exception_code_field_o(code_o), .pending_irq_field_o(pend_o), .status_o(status_o));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic set_sr(input logic [15:0] v);
    @(negedge clk_i);
    sr_wr_i = 1'b1;
    sr_wdata_i = v;
    @(negedge clk_i);
    sr_wr_i = 1'b0;
  endtask
  // n counts falling edges from the stimulus to the visible entry
  task automatic entry(input int n, input logic [31:0] vec, input logic [4:0] code);
    for (int i = 1; i < n; i++) begin
      @(negedge clk_i);
      check(vec_load_o, 1'b0, "early entry");
    end
    @(negedge clk_i);
    check({abort_o, halt_o, vec_load_o}, 3'b111, "entry pulses");
    check(vec_addr_o, vec, "vector");
    check(code_o, code, "cause code");
    check(epc_o, resume_pc_i, "return address");
    check(status_o[1:0], 2'b00, "kernel mode and ie");
    other_exc_i = 1'b0;
    dreq = '0;
    areq = '0;
    @(negedge clk_i);
    check({abort_o, halt_o, vec_load_o}, 3'b000, "pulse width");
    repeat (3) @(negedge clk_i);
  endtask
  task automatic close_out();
    $display("counts: %0d compared, %0d mismatches", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk_i);
    n_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    close_out();
  end
  initial begin
    {resetn_i, pipe_run_i, other_exc_i, sr_wr_i, rfe_i, dreq, areq} = '0;
    {resume_pc_i, other_code_i, sr_wdata_i, bc_pins, bc_sel_i} = '0;
    n_errors = 0;
    n_compared = 0;
    repeat (12) @(negedge clk_i);
    resetn_i = 1'b1;
    pipe_run_i = 1'b1;
    check(vec_addr_o, `PIE_RESET_VECTOR, "reset vector");
    check(status_o, 16'h0000, "reset status");
    $display("test reset done");
    // clocked source on pending bit 3, user mode, interrupts on
    set_sr(16'h0803);
    resume_pc_i = 32'h0000_1234;
    dreq = 3'b001;
    entry(2, `PIE_GEN_VECTOR, `PIE_EXC_INT);
    check(status_o[5:0], 6'b00_1100, "mode stack push");
    $display("test direct done");
    // masked free-running source stays pending but is not taken
    set_sr(16'h0103);
    areq = 3'b010;
    repeat (5) begin
      @(negedge clk_i);
      check(vec_load_o, 1'b0, "masked source taken");
    end
    check(pend_o, 6'b00_0010, "pending mirror");
    resume_pc_i = 32'h0000_5678;
    areq = 3'b011;
    entry(3, `PIE_GEN_VECTOR, `PIE_EXC_INT);
    $display("test synchronised done");
    // a stall defers recognition until the pipeline runs again
    set_sr(16'h0803);
    pipe_run_i = 1'b0;
    dreq = 3'b001;
    repeat (4) begin
      @(negedge clk_i);
      check(vec_load_o, 1'b0, "taken in stall");
    end
    pipe_run_i = 1'b1;
    entry(1, `PIE_GEN_VECTOR, `PIE_EXC_INT);
    $display("test stall done");
    // user translation misses have their own vector, others share the general one
    foreach (u_codes[i]) begin
      @(negedge clk_i);
      other_code_i = u_codes[i];
      other_exc_i = 1'b1;
      entry(1, (i < 2) ? `PIE_UTLB_VECTOR : `PIE_GEN_VECTOR, u_codes[i]);
    end
    $display("test other exceptions done");
    // a write during entry is refused, one cycle later it lands; rfe pops the stack
    @(negedge clk_i);
    other_code_i = 5'h08;
    other_exc_i = 1'b1;
    @(negedge clk_i);
    other_exc_i = 1'b0;
    sr_wr_i = 1'b1;
    sr_wdata_i = 16'h010C;
    @(negedge clk_i);
    check(status_o, 16'h0800, "write refused in entry");
    @(negedge clk_i);
    sr_wr_i = 1'b0;
    rfe_i = 1'b1;
    check(status_o, 16'h010C, "write after entry");
    @(negedge clk_i);
    rfe_i = 1'b0;
    check(status_o, 16'h0103, "stack pop");
    $display("test status writes done");
    for (int p = 0; p < 8; p++) begin
      @(negedge clk_i);
      bc_pins = (p < 4) ? 4'h5 : 4'hA;
      bc_sel_i = p[1:0];
      @(negedge clk_i);
      check(bc_true_o, bc_pins[p[1:0]], "branch condition");
    end
    $display("test branch conditions done");
    close_out();
  end
endmodule
`default_nettype wire
